/* core/pao_override.sv */
// Alternate-function override logic for Port A bits 4..0 and Port B bits 3..0
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps

module pao_override
    import pao_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_clock_stretch,
    input  wire logic        serial_pin_toggle_enable,
    input  wire logic        port_a_output_bit4,
    input  wire logic        timer_a_compare_wave,
    input  wire logic        timer_a_compare_enable,
    input  wire logic        onewire_debug_tx,
    input  wire logic        power_down,
    input  wire logic        lock_bits_unprogrammed,
    input  wire logic        reset_pin_disable_fuse,
    input  wire logic        onewire_debug_fuse,
    input  wire logic        sysclk_pin_output_fuse,
    input  wire logic [1:0]  clock_source_sel,
    output logic      [4:0]  pa_pullup_override_enable,
    output logic      [4:0]  pa_pullup_override_value,
    output logic      [4:0]  pa_direction_override_enable,
    output logic      [4:0]  pa_direction_override_value,
    output logic      [4:0]  pa_value_override_enable,
    output logic      [4:0]  pa_value_override_value,
    output logic      [4:0]  pa_toggle_override_enable,
    output logic      [4:0]  pa_input_enable_override_enable,
    output logic      [4:0]  pa_input_enable_override_value,
    output logic      [3:0]  pb_pullup_override_enable,
    output logic      [3:0]  pb_pullup_override_value,
    output logic      [3:0]  pb_direction_override_enable,
    output logic      [3:0]  pb_direction_override_value,
    output logic      [3:0]  pb_value_override_enable,
    output logic      [3:0]  pb_value_override_value,
    output logic      [3:0]  pb_toggle_override_enable,
    output logic      [3:0]  pb_input_enable_override_enable,
    output logic      [3:0]  pb_input_enable_override_value,
    output logic      [4:0]  pin_change_a_source_enable,
    output logic      [3:0]  pin_change_b_source_enable
);

    // ==========================================================
    // Register storage and bus decode
    // ==========================================================
    logic [6:0]  cfg_q;     // Function enables
    logic [4:0]  pam_q;     // Port A change masks
    logic [3:0]  pbm_q;     // Port B change masks
    logic [4:0]  adoff_q;   // Analog digital-off bits
    logic [31:0] rdata_q;   // Read data, captured in setup phase
    logic [31:0] stat_w;    // Live status word
    logic [31:0] wmask;     // Byte-lane write mask
    logic        wr_acc;    // Write in access phase
    logic        mapped;    // Address hits a register
    logic        ro_hit;    // Address is the read-only word
    assign wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign mapped = (paddr == PAO_CFG_OFS) || (paddr == PAO_MASK_OFS)
                 || (paddr == PAO_ADOFF_OFS) || (paddr == PAO_STAT_OFS);
    assign ro_hit = (paddr == PAO_STAT_OFS);
    assign wr_acc = psel && penable && pwrite && mapped && !ro_hit;
    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    // Unmapped addresses and writes to the status word are errors
    assign pslverr = psel && penable && (!mapped || (pwrite && ro_hit));
    assign prdata  = rdata_q;

    // ==========================================================
    // Decoded controls
    // ==========================================================
    logic wm_hi;       // Serial wire mode upper bit
    logic start_ie;    // Serial start irq enable
    logic grp_a;       // Pin change group a enable
    logic grp_b;       // Pin change group b enable
    logic irq0_en;     // External irq zero enable
    logic ext_ref;     // Reference pin in use on A0
    logic rst_dis;     // Reset pin function disabled
    logic dbg_act;     // One-wire debug active
    logic own_b3;      // B3 taken by reset or debug
    logic clk_out;     // System clock on B2
    logic xtal_sel;    // Crystal choice on B0/B1
    logic extclk_sel;  // External clock on B0
    logic claim_b0;    // B0 taken from general I/O
    logic [4:0] pa_pc; // Port A change enables
    logic [3:0] pb_pc; // Port B change enables
    assign wm_hi    = cfg_q[PAO_CFG_WMHI];
    assign start_ie = cfg_q[PAO_CFG_SIE];
    assign grp_a    = cfg_q[PAO_CFG_GA];
    assign grp_b    = cfg_q[PAO_CFG_GB];
    assign irq0_en  = cfg_q[PAO_CFG_EXTERNAL_IRQ_ZERO];
    // Either reference choice with the low select bit set uses the pin
    assign ext_ref  = cfg_q[PAO_CFG_VLO];
    // Fuses read zero when programmed
    assign rst_dis  = (reset_pin_disable_fuse == PAO_FUSE_PROG);
    assign dbg_act  = (onewire_debug_fuse == PAO_FUSE_PROG)
                   && lock_bits_unprogrammed;
    // Reset pin role or debug role both take the pin away from I/O
    assign own_b3   = !rst_dis || dbg_act;
    // Fuse level, not a register, so it holds through reset
    assign clk_out  = (sysclk_pin_output_fuse == PAO_FUSE_PROG);
    assign xtal_sel = (clock_source_sel == PAO_CLK_XTAL)
                   || (clock_source_sel == PAO_CLK_LFXT);
    assign extclk_sel = (clock_source_sel == PAO_CLK_EXT);
    assign claim_b0 = (clock_source_sel != PAO_CLK_RC);
    assign pa_pc    = pam_q & {PAO_PA_N{grp_a}};
    assign pb_pc    = pbm_q & {PAO_PB_N{grp_b}};
    assign pin_change_a_source_enable = pa_pc;
    assign pin_change_b_source_enable = pb_pc;

    // ==========================================================
    // Register write path
    // ==========================================================
    // Function enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= PAO_CFG_RST;
        end
        else if (wr_acc && (paddr == PAO_CFG_OFS))
        begin
            cfg_q <= (cfg_q & ~wmask[6:0]) | (pwdata[6:0] & wmask[6:0]);
        end
    end

    // Change masks for both ports
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pam_q <= PAO_PAM_RST;
            pbm_q <= PAO_PBM_RST;
        end
        else if (wr_acc && (paddr == PAO_MASK_OFS))
        begin
            pam_q <= (pam_q & ~wmask[4:0]) | (pwdata[4:0] & wmask[4:0]);
            pbm_q <= (pbm_q & ~wmask[11:8]) | (pwdata[11:8] & wmask[11:8]);
        end
    end

    // Analog digital-off bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adoff_q <= PAO_ADOFF_RST;
        end
        else if (wr_acc && (paddr == PAO_ADOFF_OFS))
        begin
            adoff_q <= (adoff_q & ~wmask[4:0]) | (pwdata[4:0] & wmask[4:0]);
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    // Status shows what the block has decided, not what was written
    assign stat_w = {16'h0000, dbg_act, own_b3, clk_out, xtal_sel,
                     pb_pc, 3'h0, pa_pc};
    // Data is captured in the setup cycle so it is a flop in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q <= 32'h00000000;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                PAO_CFG_OFS:   rdata_q <= {25'h0000000, cfg_q};
                PAO_MASK_OFS:  rdata_q <= {20'h00000, pbm_q, 3'h0, pam_q};
                PAO_ADOFF_OFS: rdata_q <= {27'h0000000, adoff_q};
                PAO_STAT_OFS:  rdata_q <= stat_w;
                default:       rdata_q <= 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // Port A overrides
    // ==========================================================
    // Combinational so the pin follows its peripheral without delay
    always_comb
    begin
        pa_pullup_override_enable       = 5'h00;
        pa_pullup_override_value        = 5'h00;
        pa_direction_override_enable    = 5'h00;
        pa_direction_override_value     = 5'h00;
        pa_value_override_enable        = 5'h00;
        pa_value_override_value         = 5'h00;
        pa_toggle_override_enable       = 5'h00;
        // Bits 3..0 share one shape: change product or analog-off
        pa_input_enable_override_enable = pa_pc | adoff_q;
        pa_input_enable_override_value  = pa_pc;
        // Bit 4: serial clock pin, expression kept as printed
        pa_direction_override_enable[4] = wm_hi;
        pa_direction_override_value[4]  = (serial_clock_stretch
                                        | port_a_output_bit4) & adoff_q[4];
        pa_value_override_enable[4]     = wm_hi & adoff_q[4];
        pa_toggle_override_enable[4]    = serial_pin_toggle_enable;
        pa_input_enable_override_enable[4] = start_ie | pa_pc[4] | adoff_q[4];
        pa_input_enable_override_value[4]  = start_ie | pa_pc[4];
        // Bit 0: reference pin outside reset, all values zero
        if (presetn && ext_ref)
        begin
            pa_pullup_override_enable[0]    = 1'b1;
            pa_direction_override_enable[0] = 1'b1;
            pa_value_override_enable[0]     = 1'b1;
        end
    end

    // ==========================================================
    // Port B overrides
    // ==========================================================
    always_comb
    begin
        pb_pullup_override_value     = 4'h0;
        pb_direction_override_value  = 4'h0;
        pb_value_override_value      = 4'h0;
        pb_toggle_override_enable    = 4'h0;
        // Bit 0: crystal input pin
        pb_pullup_override_enable[0]    = claim_b0;
        pb_direction_override_enable[0] = claim_b0;
        pb_value_override_enable[0]     = claim_b0;
        pb_input_enable_override_enable[0] = claim_b0 | pb_pc[0];
        // Clock input kept alive for an external clock unless powered down
        pb_input_enable_override_value[0]  = (extclk_sel & !power_down)
                                           | (!claim_b0 & pb_pc[0]);
        // Bit 1: crystal output pin
        pb_pullup_override_enable[1]    = xtal_sel;
        pb_direction_override_enable[1] = xtal_sel;
        pb_value_override_enable[1]     = xtal_sel;
        pb_input_enable_override_enable[1] = xtal_sel | pb_pc[1];
        pb_input_enable_override_value[1]  = !xtal_sel & pb_pc[1];
        // Bit 2: clock out, compare wave, irq zero
        pb_pullup_override_enable[2]    = clk_out;
        pb_direction_override_enable[2] = clk_out;
        pb_direction_override_value[2]  = 1'b1;
        // Compare wave needs software to set the pin direction
        pb_value_override_enable[2]     = clk_out | timer_a_compare_enable;
        // Clock path is unregistered on purpose; a flop cannot carry it
        pb_value_override_value[2]      = clk_out ? pclk : timer_a_compare_wave;
        pb_input_enable_override_enable[2] = irq0_en | pb_pc[2];
        pb_input_enable_override_value[2]  = irq0_en | pb_pc[2];
        // Bit 3: reset pin or one-wire debug line
        pb_pullup_override_enable[3]    = own_b3;
        pb_pullup_override_value[3]     = 1'b1;
        pb_direction_override_enable[3] = own_b3;
        // Open drain: value is zero, direction pulses while sending
        pb_direction_override_value[3]  = dbg_act & onewire_debug_tx;
        pb_value_override_enable[3]     = own_b3;
        pb_input_enable_override_enable[3] = own_b3 | pb_pc[3];
        pb_input_enable_override_value[3]  = dbg_act | (!own_b3 & pb_pc[3]);
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    // Setup then access of a config write
    sequence s_cfg_write;
        psel && !penable && pwrite && (paddr == PAO_CFG_OFS) && pstrb[0]
        ##1 psel && penable;
    endsequence
    sequence s_cfg_read;
        psel && !penable && !pwrite && (paddr == PAO_CFG_OFS)
        ##1 psel && penable;
    endsequence
    a_cfg_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_write |=> (cfg_q == $past(pwdata[6:0], 1)))
        else $error("config write not stored");
    a_cfg_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_read |-> (prdata[6:0] == cfg_q) && pready)
        else $error("config read mismatch");
    a_wire_mode_dir: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cfg_q[PAO_CFG_WMHI]) |-> pa_direction_override_enable[4])
        else $error("serial mode did not take pin direction");
    a_a4_input_en: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_q[PAO_CFG_SIE] || (pam_q[4] && cfg_q[PAO_CFG_GA]))
        |-> pa_input_enable_override_value[4] && pa_input_enable_override_enable[4])
        else $error("pin A4 input not forced");
    a_a3_input_en: assert property (@(posedge pclk) disable iff (!presetn)
        pa_input_enable_override_enable[3]
        == ((pam_q[3] && cfg_q[PAO_CFG_GA]) || adoff_q[3]))
        else $error("pin A3 input override wrong");
    a_ref_pin_off: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_q[PAO_CFG_VLO] |-> pa_pullup_override_enable[0]
        && !pa_pullup_override_value[0] && !pa_value_override_value[0])
        else $error("reference pin not released");
    a_b0_claim: assert property (@(posedge pclk) disable iff (!presetn)
        pb_direction_override_enable[0] == (clock_source_sel != PAO_CLK_RC))
        else $error("pin B0 claim wrong");
    a_b1_claim: assert property (@(posedge pclk) disable iff (!presetn)
        pb_pullup_override_enable[1] == clock_source_sel[1])
        else $error("pin B1 claim wrong");
    a_clkout_dir: assert property (@(posedge pclk) disable iff (!presetn)
        !sysclk_pin_output_fuse |-> pb_direction_override_enable[2]
        && pb_direction_override_value[2])
        else $error("clock output pin not driven");
    a_b2_input_en: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cfg_q[PAO_CFG_EXTERNAL_IRQ_ZERO]) |-> pb_input_enable_override_value[2])
        else $error("pin B2 input not forced");
    a_reset_pin_role: assert property (@(posedge pclk) disable iff (!presetn)
        (reset_pin_disable_fuse && !dbg_act) |-> pb_pullup_override_value[3]
        && !pb_direction_override_value[3] && !pb_input_enable_override_value[3])
        else $error("reset pin role wrong");
    a_change_b_map: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_q[PAO_CFG_GB] |-> (pin_change_b_source_enable == 4'h0))
        else $error("group b change leaks");
endmodule

/* core/pao_pkg.sv */
// Constants and types shared by the port alternate-function override logic
package pao_pkg;

    // ==========================================================
    // Register map (byte addresses, one aligned word each)
    // ==========================================================
    localparam logic [11:0] PAO_CFG_OFS   = 12'h000; // Function enables
    localparam logic [11:0] PAO_MASK_OFS  = 12'h004; // Pin change masks
    localparam logic [11:0] PAO_ADOFF_OFS = 12'h008; // Analog digital-off
    localparam logic [11:0] PAO_STAT_OFS  = 12'h00C; // Read-only state

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int PAO_CFG_WMHI   = 0; // Serial wire mode, upper bit
    localparam int PAO_CFG_SIE    = 1; // Serial start irq enable
    localparam int PAO_CFG_GA     = 2; // Pin change group a enable
    localparam int PAO_CFG_GB     = 3; // Pin change group b enable
    localparam int PAO_CFG_EXTERNAL_IRQ_ZERO   = 4; // External irq zero enable
    localparam int PAO_CFG_VLO    = 5; // Reference select, low bit
    localparam int PAO_CFG_VHI    = 6; // Reference select, high bit
    localparam int PAO_CFG_W      = 7; // Width of the config field
    localparam int PAO_MASK_PB_LO = 8; // Port B masks start here
    localparam int PAO_PA_N       = 5; // Port A pins covered
    localparam int PAO_PB_N       = 4; // Port B pins covered

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [6:0] PAO_CFG_RST   = 7'h00;
    localparam logic [4:0] PAO_PAM_RST   = 5'h00;
    localparam logic [3:0] PAO_PBM_RST   = 4'h0;
    localparam logic [4:0] PAO_ADOFF_RST = 5'h00;

    // Fuse level that means programmed
    localparam logic PAO_FUSE_PROG = 1'b0;

    // System clock choice presented by the clock control block
    typedef enum logic [1:0] {
        PAO_CLK_RC    = 2'h0, // Internal calibrated RC oscillator
        PAO_CLK_EXT   = 2'h1, // External clock on the crystal input pin
        PAO_CLK_XTAL  = 2'h2, // Crystal oscillator
        PAO_CLK_LFXT  = 2'h3  // Low-frequency crystal oscillator
    } pao_clksel_t;

endpackage

/* testbench/pao_pin_partner.sv */
// Pin-side model of the shared reset/debug line and the debug emulator on it
`timescale 1ns/1ps

module pao_pin_partner
(
    input  wire logic dev_oe,        // Device enables its driver (drives low)
    input  wire logic emu_drive_low, // Emulator pulls the shared line low
    output logic      line           // Resolved level seen by all parties
);
    // ==========================================================
    // Wire-AND resolution
    // ==========================================================
    // Open drain: anyone pulling low wins, otherwise pull-up gives 1
    always_comb
    begin
        line = 1'b1;
        if (dev_oe || emu_drive_low)
        begin
            line = 1'b0;
        end
    end
endmodule

/* testbench/test_port_alternate_function_override.sv */
// Self-checking testbench for the port alternate-function override block
`timescale 1ns/1ps

module test_port_alternate_function_override;
    import pao_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    typedef struct packed {
        logic [6:0] cfg; logic [11:0] mask; logic [4:0] adoff; logic [1:0] clk;
        logic [2:0] fz; logic [4:0] ie_en; logic [4:0] ie_val; logic [4:0] dd_en;
        logic [3:0] pu_en; logic [3:0] pbdd_en; logic [3:0] pcb;
    } pao_row_t; // Fuses packed as {reset, debug, clock out}, 0 = programmed
    pao_row_t rows [11];
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic serial_clock_stretch = 0, serial_pin_toggle_enable = 0, port_a_output_bit4 = 0;
    logic timer_a_compare_wave = 0, timer_a_compare_enable = 0, onewire_debug_tx = 0;
    logic power_down = 0, lock_bits_unprogrammed = 1, emu_low = 0, line, er;
    logic reset_pin_disable_fuse = 1, onewire_debug_fuse = 1, sysclk_pin_output_fuse = 1;
    logic [1:0] clock_source_sel = 2'h0;
    logic [4:0] pa_pullup_override_enable, pa_pullup_override_value, pa_toggle_override_enable;
    logic [4:0] pa_direction_override_enable, pa_direction_override_value;
    logic [4:0] pa_value_override_enable, pa_value_override_value;
    logic [4:0] pa_input_enable_override_enable, pa_input_enable_override_value;
    logic [3:0] pb_pullup_override_enable, pb_pullup_override_value, pb_toggle_override_enable;
    logic [3:0] pb_direction_override_enable, pb_direction_override_value;
    logic [3:0] pb_value_override_enable, pb_value_override_value;
    logic [3:0] pb_input_enable_override_enable, pb_input_enable_override_value;
    logic [4:0] pin_change_a_source_enable;
    logic [3:0] pin_change_b_source_enable;
    int n_mismatch = 0, check_count = 0;

    pao_override u_pao_override (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .serial_clock_stretch, .serial_pin_toggle_enable,
        .port_a_output_bit4, .timer_a_compare_wave, .timer_a_compare_enable, .onewire_debug_tx,
        .power_down, .lock_bits_unprogrammed, .reset_pin_disable_fuse, .onewire_debug_fuse,
        .sysclk_pin_output_fuse, .clock_source_sel, .pa_pullup_override_enable,
        .pa_pullup_override_value, .pa_direction_override_enable, .pa_direction_override_value,
        .pa_value_override_enable, .pa_value_override_value, .pa_toggle_override_enable,
        .pa_input_enable_override_enable, .pa_input_enable_override_value,
        .pb_pullup_override_enable, .pb_pullup_override_value, .pb_direction_override_enable,
        .pb_direction_override_value, .pb_value_override_enable, .pb_value_override_value,
        .pb_toggle_override_enable, .pb_input_enable_override_enable,
        .pb_input_enable_override_value, .pin_change_a_source_enable,
        .pin_change_b_source_enable);

    // Device drives the shared line only while its B3 driver is enabled and low
    pao_pin_partner u_pao_pin_partner (.dev_oe(pb_direction_override_enable[3]
        & pb_direction_override_value[3] & ~pb_value_override_value[3]),
        .emu_drive_low(emu_low), .line(line));

    // ==========================================================
    // Clock, watchdog and shared tasks
    // ==========================================================
    always #5 pclk = ~pclk;
    // Whole run is under two hundred cycles; far beyond that means a hang
    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        //      cfg    mask    adoff  clk  fz      ie_en  ie_val dd_en  pu    pbdd  pcb
        rows[0]  = '{7'h00, 12'h000, 5'h00, 2'h0, 3'b111, 5'h00, 5'h00, 5'h00, 4'h8, 4'h8, 4'h0};
        rows[1]  = '{7'h01, 12'h000, 5'h00, 2'h0, 3'b111, 5'h00, 5'h00, 5'h10, 4'h8, 4'h8, 4'h0};
        rows[2]  = '{7'h04, 12'h01B, 5'h00, 2'h0, 3'b111, 5'h1B, 5'h1B, 5'h00, 4'h8, 4'h8, 4'h0};
        rows[3]  = '{7'h00, 12'h000, 5'h1F, 2'h0, 3'b111, 5'h1F, 5'h00, 5'h00, 4'h8, 4'h8, 4'h0};
        rows[4]  = '{7'h02, 12'h000, 5'h00, 2'h0, 3'b111, 5'h10, 5'h10, 5'h00, 4'h8, 4'h8, 4'h0};
        rows[5]  = '{7'h08, 12'hF00, 5'h00, 2'h2, 3'b010, 5'h00, 5'h00, 5'h00, 4'h7, 4'h7, 4'hF};
        rows[6]  = '{7'h00, 12'h000, 5'h00, 2'h1, 3'b111, 5'h00, 5'h00, 5'h00, 4'h9, 4'h9, 4'h0};
        rows[7]  = '{7'h00, 12'h000, 5'h00, 2'h3, 3'b001, 5'h00, 5'h00, 5'h00, 4'hB, 4'hB, 4'h0};
        rows[8]  = '{7'h20, 12'h000, 5'h00, 2'h0, 3'b111, 5'h00, 5'h00, 5'h01, 4'h8, 4'h8, 4'h0};
        rows[9]  = '{7'h04, 12'h004, 5'h00, 2'h0, 3'b111, 5'h04, 5'h04, 5'h00, 4'h8, 4'h8, 4'h0};
        rows[10] = '{7'h00, 12'hF1F, 5'h00, 2'h0, 3'b111, 5'h00, 5'h00, 5'h00, 4'h8, 4'h8, 4'h0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Table of ordinary override cases
        foreach (rows[i])
        begin
            @(posedge pclk);
            {reset_pin_disable_fuse, onewire_debug_fuse, sysclk_pin_output_fuse} <= rows[i].fz;
            clock_source_sel <= rows[i].clk;
            apb(PAO_CFG_OFS, 1'b1, {25'h0, rows[i].cfg});
            apb(PAO_MASK_OFS, 1'b1, {20'h0, rows[i].mask});
            apb(PAO_ADOFF_OFS, 1'b1, {27'h0, rows[i].adoff});
            settle();
            chk(pa_input_enable_override_enable, rows[i].ie_en, "pa ie en");
            chk(pa_input_enable_override_value, rows[i].ie_val, "pa ie val");
            chk(pa_direction_override_enable, rows[i].dd_en, "pa dir en");
            chk(pb_pullup_override_enable, rows[i].pu_en, "pb pu en");
            chk(pb_direction_override_enable, rows[i].pbdd_en, "pb dir en");
            chk(pb_value_override_enable, rows[i].pu_en, "pb val en");
            chk({pin_change_b_source_enable, pin_change_a_source_enable[3:0]},
                {rows[i].pcb, rows[i].ie_val[3:0]}, "pc src");
            $display("test row %0d done", i);
        end
        // Clock output on B2, kept through reset, else compare wave
        apb(PAO_CFG_OFS, 1'b1, 32'h0);
        sysclk_pin_output_fuse <= 1'b0;
        settle();
        chk({pb_direction_override_enable[2], pb_direction_override_value[2]}, 2'h3, "ck");
        @(posedge pclk) presetn <= 1'b0;
        settle();
        chk(pb_value_override_value[2], 1'b1, "clk high in reset");
        @(negedge pclk);
        #1;
        chk(pb_value_override_value[2], 1'b0, "clk low in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        sysclk_pin_output_fuse <= 1'b1;
        timer_a_compare_enable <= 1'b1;
        timer_a_compare_wave <= 1'b1;
        settle();
        chk({pb_value_override_enable[2], pb_value_override_value[2]}, 2'h3, "wave");
        @(posedge pclk) timer_a_compare_wave <= 1'b0;
        settle();
        chk(pb_value_override_value[2], 1'b0, "wave low");
        // Register reset values after the mid-run reset, width masking, refused accesses
        foreach (rows[i]) if (i < 3) begin apb(12'(4 * i), 1'b0, 32'h0); chk(rd, 32'h0, "rst"); end
        apb(PAO_CFG_OFS, 1'b1, 32'hFFFFFFFF);
        apb(PAO_CFG_OFS, 1'b0, 32'h0);
        chk(rd, 32'h0000007F, "cfg width");
        apb(PAO_STAT_OFS, 1'b1, 32'h0);
        chk({31'h0, er}, 32'h1, "stat write refused");
        apb(12'h010, 1'b0, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
        $display("test registers done");
        apb(PAO_CFG_OFS, 1'b1, 32'h10);
        settle();
        chk({pb_input_enable_override_enable[2], pb_input_enable_override_value[2]}, 2'h3,
            "external_irq_zero");
        $display("test port b2 done");
        // Reset role, then debug line shared with the emulator
        chk({pb_pullup_override_value[3], pb_input_enable_override_value[3]}, 2'h2, "rst");
        @(posedge pclk) {reset_pin_disable_fuse, onewire_debug_fuse, onewire_debug_tx} <= 3'b001;
        settle();
        chk({line, pb_input_enable_override_value[3]}, 2'h1, "debug tx");
        @(posedge pclk) onewire_debug_tx <= 1'b0;
        settle();
        chk(line, 1'b1, "debug idle");
        @(posedge pclk) emu_low <= 1'b1;
        settle();
        chk(line, 1'b0, "emulator low");
        $display("test port b3 done");
        // Serial wire mode on A4 direction value and toggle
        apb(PAO_CFG_OFS, 1'b1, 32'h01);
        apb(PAO_ADOFF_OFS, 1'b1, 32'h10);
        serial_clock_stretch <= 1'b1;
        serial_pin_toggle_enable <= 1'b1;
        settle();
        chk({pa_direction_override_value[4], pa_toggle_override_enable[4]}, 2'h3, "a4");
        @(posedge pclk) serial_clock_stretch <= 1'b0;
        settle();
        chk(pa_direction_override_value[4], 1'b0, "a4 low");
        $display("test port a4 done");
        close_out();
    end
endmodule
